// ==== logic/serial_register_access_port.sv ====
// Serial (SPI or I2C) slave giving a host access to 16-bit registers
`timescale 1ns/1ns
`include "sra_params.svh"
module serial_register_access_port (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // Variant strap, high selects I2C
  input  wire logic                     i2c_mode,
  // SPI pins
  input  wire logic                     spi_sclk,
  input  wire logic                     spi_cs_n,
  input  wire logic                     spi_din,
  output logic                          spi_dout,
  output logic                          spi_dout_oe,
  // I2C pins
  input  wire logic                     i2c_scl,
  input  wire logic                     i2c_sda_in,
  output logic                          i2c_sda_out,
  output logic                          i2c_sda_oe,
  input  wire logic                     addr_select_lo,
  input  wire logic                     addr_select_hi,
  // Register file side
  output logic [`SRA_ADDR_W-1:0]        reg_rd_addr,
  input  wire logic [`SRA_WORD_W-1:0]   reg_rd_data,
  output logic                          reg_wr_valid,
  output logic [`SRA_ADDR_W-1:0]        reg_wr_addr,
  output logic [`SRA_WORD_W-1:0]        reg_wr_data,
  input  wire logic                     reg_wr_ready
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [`SRA_PIN_N-1:0] pin_raw, s1_q, s2_q, s3_q;
  assign pin_raw = {addr_select_hi, addr_select_lo, i2c_mode, i2c_sda_in,
                    i2c_scl, spi_din, spi_cs_n, spi_sclk};

  for (genvar i = 0; i < `SRA_PIN_N; i++) begin : g_sync
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_q[i] <= 1'b1;
        s2_q[i] <= 1'b1;
        s3_q[i] <= 1'b1;
      end else begin
        s1_q[i] <= pin_raw[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
      end
    end
  end

  function automatic logic rose(input int i);
    return s2_q[i] && !s3_q[i];
  endfunction

  function automatic logic fell(input int i);
    return !s2_q[i] && s3_q[i];
  endfunction

  logic r_sclk, f_sclk, r_scl, f_scl, start_c, stop_c;
  assign r_sclk  = rose(`SRA_PIN_SCLK);
  assign f_sclk  = fell(`SRA_PIN_SCLK);
  assign r_scl   = rose(`SRA_PIN_SCL);
  assign f_scl   = fell(`SRA_PIN_SCL);
  assign start_c = s2_q[`SRA_PIN_SCL] && s3_q[`SRA_PIN_SCL] && fell(`SRA_PIN_SDA);
  assign stop_c  = s2_q[`SRA_PIN_SCL] && s3_q[`SRA_PIN_SCL] && rose(`SRA_PIN_SDA);

  // ************************************************************
  // Write buffer
  // ************************************************************
  wr_fifo_if #(.W(`SRA_FIFO_W)) fq ();
  wr_fifo #(.W(`SRA_FIFO_W), .D(`SRA_FIFO_DEPTH)) u_fifo (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .f       (fq.buffer)
  );

  // ************************************************************
  // Protocol state
  // ************************************************************
  sra_pkg::spi_state_t   sp_q, sp_d;
  sra_pkg::i2c_state_t   ic_q, ic_d;
  logic [3:0]            cnt_q, cnt_d;
  logic [15:0]           sh_q, sh_d, tx_q, tx_d, cmd_w;
  logic [9:0]            ptr_q, ptr_d;
  logic                  end_q, end_d, mode_q, mode_d, dout_q, dout_d;
  logic                  doe_q, doe_d, soe_q, soe_d, rw_q, rw_d, hi_q, hi_d;
  logic [1:0]            bidx_q, bidx_d;
  logic [7:0]            hib_q, hib_d, byte_w;
  logic                  push_q, push_d, cmd_ok, ptr_load;
  logic [`SRA_FIFO_W-1:0] pdat_q, pdat_d;

  assign cmd_w  = {sh_q[14:0], s2_q[`SRA_PIN_DIN]};
  assign byte_w = {sh_q[6:0], s2_q[`SRA_PIN_SDA]};
  assign cmd_ok = !mode_q && sp_q == sra_pkg::SP_CMD && r_sclk && cnt_q == `SRA_CNT_LAST
                  && cmd_w[15:11] == `SRA_ENABLE;

  always_comb begin
    sp_d = sp_q;  ic_d = ic_q;  cnt_d = cnt_q;  sh_d = sh_q;  tx_d = tx_q;
    ptr_d = ptr_q;  end_d = end_q;  dout_d = dout_q;  doe_d = doe_q;  soe_d = soe_q;
    rw_d = rw_q;  hi_d = hi_q;  bidx_d = bidx_q;  hib_d = hib_q;  pdat_d = pdat_q;
    ptr_load = 1'b0;
    push_d = push_q && !fq.push_ready;
    // Strap only follows the pin while both sides rest
    mode_d = (sp_q == sra_pkg::SP_IDLE && ic_q == sra_pkg::I_IDLE)
             ? s2_q[`SRA_PIN_MODE] : mode_q;
    if (!mode_q) begin
      if (s2_q[`SRA_PIN_CS_N]) begin
        sp_d  = sra_pkg::SP_IDLE;
        doe_d = 1'b0;
        cnt_d = '0;
      end else begin
        unique case (sp_q)
          sra_pkg::SP_IDLE: sp_d = sra_pkg::SP_CMD;
          sra_pkg::SP_CMD: if (r_sclk) begin
            sh_d  = cmd_w;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == `SRA_CNT_LAST) begin
              if (cmd_w[15:11] == `SRA_ENABLE) begin
                ptr_d    = cmd_w[9:0];
                ptr_load = 1'b1;
                end_d    = 1'b0;
                sp_d     = cmd_w[10] ? sra_pkg::SP_RD : sra_pkg::SP_WR;
              end else begin
                sp_d = sra_pkg::SP_IGN;
              end
            end
          end
          sra_pkg::SP_WR: if (r_sclk) begin
            sh_d  = cmd_w;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == `SRA_CNT_LAST && !end_q) begin
              push_d = 1'b1;
              pdat_d = {ptr_q, cmd_w};
              if (ptr_q == `SRA_PTR_MAX) end_d = 1'b1;
              else ptr_d = ptr_q + 10'h001;
            end
          end
          sra_pkg::SP_RD: if (f_sclk) begin
            cnt_d = cnt_q + 4'h1;
            doe_d = 1'b1;
            if (cnt_q == '0) begin
              dout_d = reg_rd_data[15];
              tx_d   = {reg_rd_data[14:0], 1'b0};
              if (ptr_q != `SRA_PTR_MAX) ptr_d = ptr_q + 10'h001;
            end else begin
              dout_d = tx_q[15];
              tx_d   = {tx_q[14:0], 1'b0};
            end
          end
          sra_pkg::SP_IGN: ;
        endcase
      end
    end else if (stop_c) begin
      ic_d  = sra_pkg::I_IDLE;
      soe_d = 1'b0;
    end else if (start_c) begin
      ic_d  = sra_pkg::I_ADDR;
      cnt_d = '0;
      soe_d = 1'b0;
    end else begin
      unique case (ic_q)
        sra_pkg::I_IDLE: ;
        sra_pkg::I_ADDR, sra_pkg::I_WR, sra_pkg::I_RACK: begin
          if (r_scl) begin
            sh_d  = {8'h00, byte_w};
            cnt_d = cnt_q + 4'h1;
          end else if (f_scl && ic_q == sra_pkg::I_ADDR && cnt_q == `SRA_CNT_BYTE) begin
            if (sh_q[7:1] == {`SRA_I2C_ADDR_HI, s2_q[`SRA_PIN_SEL_HI],
                              s2_q[`SRA_PIN_SEL_LO]}) begin
              soe_d = 1'b1;
              rw_d  = sh_q[0];
              ic_d  = sra_pkg::I_AACK;
            end else begin
              ic_d = sra_pkg::I_IDLE;
            end
          end else if (f_scl && ic_q == sra_pkg::I_WR && cnt_q == `SRA_CNT_BYTE) begin
            soe_d = 1'b1;
            ic_d  = sra_pkg::I_WACK;
            if (bidx_q == 2'h0) begin
              ptr_d    = {2'b00, sh_q[7:0]};
              ptr_load = 1'b1;
              end_d    = 1'b0;
              bidx_d   = 2'h1;
            end else if (bidx_q == 2'h1) begin
              hib_d  = sh_q[7:0];
              bidx_d = 2'h2;
            end else begin
              bidx_d = 2'h1;
              if (!end_q) begin
                push_d = 1'b1;
                pdat_d = {ptr_q, hib_q, sh_q[7:0]};
                if (ptr_q == `SRA_PTR_MAX) end_d = 1'b1;
                else ptr_d = ptr_q + 10'h001;
              end
            end
          end else if (f_scl && ic_q == sra_pkg::I_RACK) begin
            if (sh_q[0]) ic_d = sra_pkg::I_IDLE;
            else begin
              ic_d  = sra_pkg::I_RD;
              cnt_d = '0;
              hi_d  = !hi_q;
              tx_d  = {hi_q ? reg_rd_data[15:8] : reg_rd_data[7:0], 8'h00};
              soe_d = !(hi_q ? reg_rd_data[15] : reg_rd_data[7]);
              if (!hi_q && ptr_q != `SRA_PTR_MAX) ptr_d = ptr_q + 10'h001;
            end
          end
        end
        sra_pkg::I_AACK: if (f_scl) begin
          cnt_d  = '0;
          bidx_d = 2'h0;
          if (rw_q) begin
            ic_d  = sra_pkg::I_RD;
            hi_d  = 1'b0;
            tx_d  = {reg_rd_data[15:8], 8'h00};
            soe_d = !reg_rd_data[15];
          end else begin
            ic_d  = sra_pkg::I_WR;
            soe_d = 1'b0;
          end
        end
        sra_pkg::I_WACK: if (f_scl) begin
          soe_d = 1'b0;
          cnt_d = '0;
          ic_d  = sra_pkg::I_WR;
        end
        sra_pkg::I_RD: begin
          if (r_scl) cnt_d = cnt_q + 4'h1;
          else if (f_scl) begin
            tx_d = {tx_q[14:0], 1'b0};
            if (cnt_q == `SRA_CNT_BYTE) begin
              soe_d = 1'b0;
              ic_d  = sra_pkg::I_RACK;
            end else begin
              soe_d = !tx_q[14];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_q <= sra_pkg::SP_IDLE;  ic_q <= sra_pkg::I_IDLE;  cnt_q <= '0;
      sh_q <= '0;  tx_q <= '0;  ptr_q <= '0;  end_q <= 1'b0;  mode_q <= 1'b0;
      dout_q <= 1'b0;  doe_q <= 1'b0;  soe_q <= 1'b0;  rw_q <= 1'b0;  hi_q <= 1'b0;
      bidx_q <= '0;  hib_q <= '0;  push_q <= 1'b0;  pdat_q <= '0;
    end else begin
      sp_q <= sp_d;  ic_q <= ic_d;  cnt_q <= cnt_d;
      sh_q <= sh_d;  tx_q <= tx_d;  ptr_q <= ptr_d;  end_q <= end_d;  mode_q <= mode_d;
      dout_q <= dout_d;  doe_q <= doe_d;  soe_q <= soe_d;  rw_q <= rw_d;  hi_q <= hi_d;
      bidx_q <= bidx_d;  hib_q <= hib_d;  push_q <= push_d;  pdat_q <= pdat_d;
    end
  end

  // A word still waiting when the next completes is lost; at 16 (SPI) or 18 (I2C)
  // link bits per word the buffer only overflows if the register side stalls long
  assign fq.push_valid = push_q;
  assign fq.push_data  = pdat_q;
  assign fq.pop_ready  = reg_wr_ready;
  assign reg_wr_valid  = fq.pop_valid;
  assign reg_wr_addr   = fq.pop_data[`SRA_FIFO_W-1:`SRA_WORD_W];
  assign reg_wr_data   = fq.pop_data[`SRA_WORD_W-1:0];
  assign reg_rd_addr   = ptr_q;
  assign spi_dout      = dout_q;
  assign spi_dout_oe   = doe_q;
  assign i2c_sda_oe    = soe_q;
  assign i2c_sda_out   = 1'b0;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sclk_sample_a: assert property (!mode_q && sp_q == sra_pkg::SP_CMD && r_sclk
    && !s2_q[`SRA_PIN_CS_N] |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("command bit not taken on rising clock");
  dout_edge_a: assert property ($changed(dout_q) |-> $past(f_sclk))
    else $error("data output changed off a falling clock");
  enable_reject_a: assert property (!mode_q && !s2_q[`SRA_PIN_CS_N]
    && sp_q == sra_pkg::SP_CMD && r_sclk && cnt_q == `SRA_CNT_LAST
    && cmd_w[15:11] != `SRA_ENABLE |=> sp_q == sra_pkg::SP_IGN)
    else $error("bad enable pattern accepted");
  dir_select_a: assert property (cmd_ok && !s2_q[`SRA_PIN_CS_N] |=> sp_q == ($past(cmd_w[10])
    ? sra_pkg::SP_RD : sra_pkg::SP_WR) && ptr_q == $past(cmd_w[9:0]))
    else $error("wrong direction or start address");
  word_push_a: assert property (push_q && !fq.push_ready |=> push_q
    && $stable(pdat_q))
    else $error("pending write word lost");
  no_wrap_a: assert property (end_q && !ptr_load |=> $stable(ptr_q))
    else $error("pointer moved past its maximum");
  dout_hiz_a: assert property (sp_q != sra_pkg::SP_RD |=> !doe_q)
    else $error("data output driven outside read");
  addr_ack_a: assert property (ic_q == sra_pkg::I_AACK |-> soe_q)
    else $error("address not acknowledged");
  stop_idle_a: assert property (mode_q && stop_c |=> ic_q == sra_pkg::I_IDLE
    && !soe_q)
    else $error("stop did not return to idle");
  slave_only_a: assert property (soe_q |-> ic_q inside {sra_pkg::I_AACK,
    sra_pkg::I_WACK, sra_pkg::I_RD, sra_pkg::I_RACK})
    else $error("data line driven outside a slave slot");

  spi_read_c: cover property (sp_q == sra_pkg::SP_RD && doe_q);
  spi_write_c: cover property (!mode_q && push_q);
  i2c_write_c: cover property (mode_q && push_q);
  i2c_read_c: cover property (ic_q == sra_pkg::I_RACK);
endmodule

// ==== logic/wr_fifo.sv ====
// Write buffer between the serial side and the register file
`timescale 1ns/1ns
module wr_fifo #(
  parameter int W = 26,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Both sides
  wr_fifo_if.buffer f
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          do_push, do_pop;
  logic          vld_q, vld_d;

  // Count is one bit wider than the index so that full can be told from empty
  assign f.push_ready = (cnt_q != (AW+1)'(D));
  // Valid comes from its own flop so the register side sees a clean level
  assign f.pop_valid  = vld_q;
  assign f.pop_data   = mem_q[rd_q];

  always_comb begin
    do_push = f.push_valid && f.push_ready;
    do_pop  = f.pop_valid && f.pop_ready;
    wr_d = do_push ? ((wr_q == AW'(D - 1)) ? '0 : wr_q + AW'(1)) : wr_q;
    rd_d = do_pop ? ((rd_q == AW'(D - 1)) ? '0 : rd_q + AW'(1)) : rd_q;
    cnt_d = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    vld_d = (cnt_d != '0);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      vld_q <= 1'b0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      vld_q <= vld_d;
    end
  end

  // Storage has no reset; only written slots are ever read
  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem_q[wr_q] <= f.push_data;
    end
  end
endmodule

// ==== shared/sra_params.svh ====
// Constants for the serial register access port
`ifndef SRA_PARAMS_SVH
`define SRA_PARAMS_SVH
`define SRA_WORD_W      16
`define SRA_ADDR_W      10
`define SRA_FIFO_W      26
`define SRA_FIFO_DEPTH  32
`define SRA_ENABLE      5'h1C
`define SRA_PTR_MAX     10'h3FF
`define SRA_I2C_ADDR_HI 5'h0B
`define SRA_CNT_LAST    4'hF
`define SRA_CNT_BYTE    4'h8
`define SRA_PIN_N       8
`define SRA_PIN_SCLK    0
`define SRA_PIN_CS_N    1
`define SRA_PIN_DIN     2
`define SRA_PIN_SCL     3
`define SRA_PIN_SDA     4
`define SRA_PIN_MODE    5
`define SRA_PIN_SEL_LO  6
`define SRA_PIN_SEL_HI  7
`endif

// ==== shared/sra_pkg.sv ====
// Types for the serial register access port
package sra_pkg;
  typedef enum logic [2:0] {SP_IDLE, SP_CMD, SP_WR, SP_RD, SP_IGN} spi_state_t;
  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK
  } i2c_state_t;
endpackage

// ==== shared/wr_fifo_if.sv ====
// Carrier between the port logic and its write buffer
`timescale 1ns/1ns
interface wr_fifo_if #(parameter int W = 26);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  modport filler (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
  modport buffer (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
endinterface

// ==== tb/host_model.sv ====
// Host model: SPI and I2C master on the link pins of the port
`timescale 1ns/1ns
module host_model (
  // SPI pins
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_din,
  input  wire logic spi_miso,
  input  wire logic spi_oe,
  // I2C pins, data line open drain with pull-up
  output logic      i2c_scl,
  output logic      sda_low,
  input  wire logic sda
);
  int oe_bad;

  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_din  = 1'b0;
    i2c_scl  = 1'b1;
    sda_low  = 1'b0;
    oe_bad   = 0;
  end

  // ************************************************************
  // SPI, 800 ns clock, still outside frames
  // ************************************************************
  task automatic spi_word(input logic [15:0] w, input bit quiet, output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      spi_sclk <= 1'b0;
      spi_din  <= w[i];
      #400;
      if (quiet && spi_oe !== 1'b0) oe_bad++;
      spi_sclk <= 1'b1;
      r[i] = spi_miso;
      #400;
    end
  endtask

  task automatic spi_xfer(input logic [15:0] cw, input logic [15:0] wd[$], input bit idle_hi,
                          input bit quiet, output logic [15:0] rd[$]);
    logic [15:0] r;
    rd = {};
    #37;
    spi_sclk <= idle_hi;
    #800;
    spi_cs_n <= 1'b0;
    #400;
    spi_word(cw, 1'b1, r);
    foreach (wd[k]) begin
      spi_word(wd[k], quiet, r);
      rd.push_back(r);
    end
    #400;
    spi_sclk <= idle_hi;
    #400;
    spi_cs_n <= 1'b1;
    // Released line must not keep its last level
    spi_din  <= ~spi_din;
    #2000;
  endtask

  // ************************************************************
  // I2C, data moved only while the clock is low
  // ************************************************************
  task automatic i2c_bit(input logic b, output logic r);
    #200;
    sda_low <= ~b;
    #200;
    i2c_scl <= 1'b1;
    #200;
    r = sda;
    #200;
    i2c_scl <= 1'b0;
  endtask

  task automatic i2c_byte(input logic [7:0] b, input logic ack_in, output logic [7:0] r,
                          output logic ack);
    for (int i = 7; i >= 0; i--) i2c_bit(b[i], r[i]);
    i2c_bit(ack_in, ack);
  endtask

  // Waits past the slave's release so a repeated start is not seen as a stop
  task automatic i2c_start();
    #37;
    sda_low <= 1'b0;
    #400;
    i2c_scl <= 1'b1;
    #400;
    sda_low <= 1'b1;
    #400;
    i2c_scl <= 1'b0;
  endtask

  task automatic i2c_stop();
    #200;
    sda_low <= 1'b1;
    #200;
    i2c_scl <= 1'b1;
    #400;
    sda_low <= 1'b0;
    #2000;
  endtask
endmodule

// ==== tb/serial_register_access_port_bench.sv ====
// Self-checking testbench for the serial register access port
`timescale 1ns/1ns
`include "sra_params.svh"
module serial_register_access_port_bench;
  logic        sys_clk;
  logic        rst_n;
  logic        i2c_mode;
  logic        addr_select_lo;
  logic        addr_select_hi;
  logic        reg_wr_ready;
  logic        stall;
  logic        spi_dout;
  logic        spi_dout_oe;
  logic        i2c_sda_out;
  logic        i2c_sda_oe;
  logic        reg_wr_valid;
  logic [9:0]  reg_rd_addr;
  logic [9:0]  reg_wr_addr;
  logic [15:0] reg_wr_data;
  logic [15:0] reg_rd_data;
  logic [15:0] mem [0:1023];
  logic [25:0] exp_wr[$];
  logic [15:0] wd[$];
  logic [15:0] rd[$];
  wire logic   spi_sclk, spi_cs_n, spi_din, i2c_scl, sda_low, spi_miso, sda;
  int          miscompares, checks, cyc, seed;

  assign spi_miso    = spi_dout_oe ? spi_dout : 1'bz;
  assign sda         = ((i2c_sda_oe & ~i2c_sda_out) | sda_low) ? 1'b0 : 1'b1;
  assign reg_rd_data = mem[reg_rd_addr];

  serial_register_access_port serial_register_access_port_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .i2c_mode(i2c_mode), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe),
    .i2c_scl(i2c_scl), .i2c_sda_in(sda), .i2c_sda_out(i2c_sda_out), .i2c_sda_oe(i2c_sda_oe),
    .addr_select_lo(addr_select_lo), .addr_select_hi(addr_select_hi),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .reg_wr_valid(reg_wr_valid),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_wr_ready(reg_wr_ready));

  host_model host_model_inst (
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_din(spi_din), .spi_miso(spi_miso),
    .spi_oe(spi_dout_oe), .i2c_scl(i2c_scl), .sda_low(sda_low), .sda(sda));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // Checking helpers
  // ************************************************************
  task automatic chk(input string what, input logic [25:0] exp, input logic [25:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [9:0] ptr_at(input logic [9:0] a, input int k);
    return (int'(a) + k > 1023) ? `SRA_PTR_MAX : 10'(int'(a) + k);
  endfunction

  // Timeout: a hang still reaches the verdict, counted as a failure
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      stop_test();
    end
  end

  // Register file: takes words, stalls at random or on demand
  always @(posedge sys_clk) begin
    if (reg_wr_valid === 1'b1 && reg_wr_ready) begin
      chk("wr_word", exp_wr.size() != 0 ? exp_wr.pop_front() : 'x,
          {reg_wr_addr, reg_wr_data});
      mem[reg_wr_addr] <= reg_wr_data;
    end
    reg_wr_ready <= stall ? 1'b0 : 1'($random(seed));
  end

  task automatic drain();
    stall <= 1'b0;
    for (int i = 0; i < 3000 && exp_wr.size() != 0; i++) @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
    chk("wr_left", 0, 26'(exp_wr.size()));
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic spi_case(input logic [9:0] a, input int n, input bit back);
    logic [15:0] w[$];
    for (int k = 0; k < n; k++) w.push_back(16'($random(seed)));
    for (int k = 0; k < n; k++) if (int'(a) + k <= 1023) exp_wr.push_back({ptr_at(a, k), w[k]});
    host_model_inst.spi_xfer({`SRA_ENABLE, 1'b0, a}, w, 1'($random(seed)), 1'b0, rd);
    drain();
    if (back) begin
      host_model_inst.spi_xfer({`SRA_ENABLE, 1'b1, a}, w, 1'($random(seed)), 1'b0, rd);
      for (int k = 0; k < n; k++) chk("rd_word", 26'(w[ptr_at(a, k) - a]), 26'(rd[k]));
      // Host clears the read indication after reads
      wd = {16'h0000};
      exp_wr.push_back({10'h081, 16'h0000});
      host_model_inst.spi_xfer({`SRA_ENABLE, 1'b0, 10'h081}, wd, 1'b0, 1'b0, rd);
      drain();
    end
    chk("oe_quiet", 0, 26'(host_model_inst.oe_bad));
    $display("test spi %h x%0d done", a, n);
  endtask

  task automatic i2c_case(input logic [1:0] sel, input bit rs);
    logic [7:0]  p;
    logic [7:0]  r;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [31:0] rv;
    logic        ack;
    logic [7:0]  bs[5];
    // Address pins follow the case so every select value is answered
    {addr_select_hi, addr_select_lo} <= sel;
    repeat (4) @(posedge sys_clk);
    p = 8'($random(seed));
    w0 = 16'($random(seed));
    w1 = 16'($random(seed));
    bs = '{p, w0[15:8], w0[7:0], w1[15:8], w1[7:0]};
    exp_wr.push_back({2'b00, p, w0});
    exp_wr.push_back({10'(p) + 10'h001, w1});
    host_model_inst.i2c_start();
    host_model_inst.i2c_byte({`SRA_I2C_ADDR_HI, sel, 1'b0}, 1'b1, r, ack);
    chk("addr_ack", 0, 26'(ack));
    for (int i = 0; i < 5; i++) begin
      host_model_inst.i2c_byte(bs[i], 1'b1, r, ack);
      chk("data_ack", 0, 26'(ack));
    end
    host_model_inst.i2c_stop();
    drain();
    host_model_inst.i2c_start();
    host_model_inst.i2c_byte({`SRA_I2C_ADDR_HI, sel, 1'b0}, 1'b1, r, ack);
    host_model_inst.i2c_byte(p, 1'b1, r, ack);
    if (!rs) host_model_inst.i2c_stop();
    host_model_inst.i2c_start();
    host_model_inst.i2c_byte({`SRA_I2C_ADDR_HI, sel, 1'b1}, 1'b1, r, ack);
    chk("rd_ack", 0, 26'(ack));
    for (int i = 0; i < 4; i++) begin
      host_model_inst.i2c_byte(8'hff, i == 3, r, ack);
      rv = {rv[23:0], r};
    end
    host_model_inst.i2c_stop();
    chk("i2c_rd_first", 26'(w0), 26'(rv[31:16]));
    chk("i2c_rd_next", 26'(w1), 26'(rv[15:0]));
    host_model_inst.i2c_start();
    host_model_inst.i2c_byte({`SRA_I2C_ADDR_HI, ~sel, 1'b0}, 1'b1, r, ack);
    chk("wrong_addr", 1, 26'(ack));
    host_model_inst.i2c_stop();
    drain();
    $display("test i2c sel %0d done", sel);
  endtask

  initial begin
    miscompares = 0;
    checks = 0;
    cyc = 0;
    seed = 32'h2fa1_51e8;
    rst_n = 1'b0;
    i2c_mode = 1'b0;
    addr_select_lo = 1'b0;
    addr_select_hi = 1'b0;
    reg_wr_ready = 1'b0;
    stall = 1'b0;
    for (int i = 0; i < 1024; i++) mem[i] = 16'($random(seed));
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int t = 0; t < 6; t++) spi_case(10'($random(seed)) & 10'h2ff, 1 + t % 3, 1'b1);
    spi_case(10'h3fe, 4, 1'b1);
    wd = {16'h1234};
    for (int b = 11; b < 16; b++) begin
      host_model_inst.spi_xfer({`SRA_ENABLE, 1'b0, 10'h005} ^ (16'h0001 << b), wd,
                               1'b0, 1'b1, rd);
    end
    drain();
    chk("bad_enable_oe", 0, 26'(host_model_inst.oe_bad));
    $display("test bad enable done");
    // Buffer overfilled by one word while the register side stalls
    stall <= 1'b1;
    spi_case(10'h100, 33, 1'b0);
    @(posedge sys_clk);
    i2c_mode <= 1'b1;
    repeat (10) @(posedge sys_clk);
    for (int s = 0; s < 4; s++) i2c_case(2'(s), s[0]);
    stop_test();
  end
endmodule
